// ### rtl/modem_packet_axi_slave.sv
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes a master that holds valid and payload until taken.
`timescale 1ns/100ps
module modem_packet_axi_slave #(
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [7:0]             wr_byte,
  input  wire logic              wr_ok,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [7:0]        rd_byte,
  input  wire logic              rd_ok
);

  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_q;
  logic [7:0]        w_q;
  logic              w_lane;

  // Address and data accepted in either order, each held once taken
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign wr_en   = aw_held && w_held && !bvalid;
  assign wr_addr = aw_q;
  assign wr_byte = w_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_q    <= '0;
      w_q     <= 8'h00;
      w_lane  <= 1'b0;
    end else if (wr_en) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_q    <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_q    <= wdata[7:0];
        w_lane <= wstrb[0];
      end
    end
  end

  // Write response one cycle after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= modem_packet_pkg::RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? modem_packet_pkg::RESP_OKAY : modem_packet_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read answered the cycle after the address is taken
  assign arready = !rvalid;
  assign rd_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= modem_packet_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rd_byte};
      rresp  <= rd_ok ? modem_packet_pkg::RESP_OKAY : modem_packet_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Lane 0 strobe gates the store in the bank, which captures its own copy; the held flag here is unused
  logic unused_lane;
  assign unused_lane = w_lane;

endmodule

// ### rtl/modem_packet_config_regs.sv
// Modem clock recovery and packet engine configuration/status register bank.
// Assumes AXI4-Lite master on aclk; modem supplies strength samples synchronously.
//
// Functional notes
// - Offset-high bits 7:5 hold oversampling ratio bits 10:8, read/write.
// - NCO offset 20 bits: high nibble, middle byte, low byte.
// - NCO middle byte resets to 0x47, low byte to 0xAE.
// - Offset-high bit 4 is a writable stall control for bit clock recovery.
// - Loop gain bits 10:8 in gain-high bits 2:0; bits 7:3 reserved.
// - Gain low byte holds gain bits 7:0, resets to 0x8F.
// - Live signal strength is read-only, resets to zero.
// - Clear-channel interrupt set when signal strength exceeds threshold.
// - Antenna one strength is read-only, resets to zero.
// - Antenna two strength is read-only.
// - Buffered mode plus control bit 7 enables receive packet handling.
// - Receive handling off: raw bits after sync go to buffer.
// - Buffered mode plus control bit 3 enables transmit packet handling.
// - Transmit handling off: send only loaded bytes, no fields added.
// - Control bit 6 selects LSB-first order, otherwise MSB-first.
// - Control bit 5 limits CRC to the data field.
// - Control bit 2 enables CRC generation.
// - Two-bit field selects CCITT, IBM, IEC-16 or Baicheva polynomial.
// - Low oversampling byte has three fractional bits, resets to 0x64.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module modem_packet_config_regs #(
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Modem measurements
  input  wire logic [7:0]        signal_strength_in,
  input  wire logic              signal_strength_valid,
  input  wire logic [7:0]        antenna1_strength_in,
  input  wire logic              antenna1_valid,
  input  wire logic [7:0]        antenna2_strength_in,
  input  wire logic              antenna2_valid,
  // Configuration outputs to modem and packet engine
  output logic [10:0]            oversampling_ratio,
  output logic                   stall_control,
  output logic [19:0]            nco_offset,
  output logic [10:0]            loop_gain,
  output logic                   clear_channel_irq,
  output logic                   rx_packet_handling,
  output logic                   rx_raw_capture,
  output logic                   tx_packet_handling,
  output logic                   tx_raw_send,
  output logic                   lsb_first,
  output logic                   crc_data_only,
  output logic                   crc_enable,
  output logic [1:0]             crc_poly_select,
  output logic [1:0]             transfer_mode
);

  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_byte;
  logic              wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        rd_byte;
  logic              rd_ok;

  logic [7:0] osr_low;
  logic [7:0] clock_recovery_offset_high;
  logic [7:0] clock_recovery_offset_mid;
  logic [7:0] clock_recovery_offset_low;
  logic [7:0] timing_loop_gain_high;
  logic [7:0] timing_loop_gain_low;
  logic [7:0] signal_strength;
  logic [7:0] clear_channel_threshold;
  logic [7:0] antenna1_strength;
  logic [7:0] antenna2_strength;
  logic [7:0] packet_access_control;
  logic [7:0] mode_control;
  logic       buffered;

  modem_packet_axi_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_byte (wr_byte),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_byte (rd_byte),
    .rd_ok   (rd_ok)
  );

  // Byte address to word index; misaligned or out-of-range yields a miss
  function automatic logic [8:0] decode_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] idx;
    idx = addr >> 2;
    if (addr[1:0] != 2'b00 || idx > ADDR_W'(255)) begin
      decode_index = 9'h100;
    end else begin
      decode_index = {1'b0, idx[7:0]};
    end
  endfunction

  // True for indices that hold a register, writable or not
  function automatic logic is_mapped(input logic [8:0] idx);
    is_mapped = !idx[8] && ((idx[7:0] >= modem_packet_pkg::IDX_OSR_LOW
                             && idx[7:0] <= modem_packet_pkg::IDX_ANT2_STRENGTH)
                            || idx[7:0] == modem_packet_pkg::IDX_PACKET_CONTROL
                            || idx[7:0] == modem_packet_pkg::IDX_MODE_CONTROL);
  endfunction

  logic [8:0] wr_idx;
  logic       wr_hit;
  logic       s_axi_wstrb_seen;
  assign wr_idx = decode_index(wr_addr);
  assign wr_ok  = is_mapped(wr_idx);
  // Lane 0 carries the byte; writes with it cleared store nothing
  assign wr_hit = wr_en && s_axi_wstrb_seen;

  // Capture lane-0 strobe alongside the data beat
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wstrb_seen <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wstrb_seen <= s_axi_wstrb[0];
    end
  end

  // Clock recovery oversampling and NCO offset registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osr_low                    <= modem_packet_pkg::RST_OSR_LOW;
      clock_recovery_offset_high <= modem_packet_pkg::RST_OFFSET_HIGH;
      clock_recovery_offset_mid  <= modem_packet_pkg::RST_OFFSET_MID;
      clock_recovery_offset_low  <= modem_packet_pkg::RST_OFFSET_LOW;
    end else if (wr_hit && !wr_idx[8]) begin
      unique case (wr_idx[7:0])
        modem_packet_pkg::IDX_OSR_LOW:     osr_low <= wr_byte;
        modem_packet_pkg::IDX_OFFSET_HIGH: clock_recovery_offset_high <= wr_byte;
        modem_packet_pkg::IDX_OFFSET_MID:  clock_recovery_offset_mid <= wr_byte;
        modem_packet_pkg::IDX_OFFSET_LOW:  clock_recovery_offset_low <= wr_byte;
        default: ;
      endcase
    end
  end

  // Loop gain, threshold, packet and mode control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timing_loop_gain_high   <= modem_packet_pkg::RST_GAIN_HIGH;
      timing_loop_gain_low    <= modem_packet_pkg::RST_GAIN_LOW;
      clear_channel_threshold <= modem_packet_pkg::RST_CC_THRESHOLD;
      packet_access_control   <= modem_packet_pkg::RST_PACKET_CONTROL;
      mode_control            <= {6'h00, modem_packet_pkg::RST_TRANSFER_MODE};
    end else if (wr_hit && !wr_idx[8]) begin
      unique case (wr_idx[7:0])
        modem_packet_pkg::IDX_GAIN_HIGH:
          timing_loop_gain_high <= wr_byte & modem_packet_pkg::MASK_GAIN_HIGH;
        modem_packet_pkg::IDX_GAIN_LOW:     timing_loop_gain_low <= wr_byte;
        modem_packet_pkg::IDX_CC_THRESHOLD: clear_channel_threshold <= wr_byte;
        modem_packet_pkg::IDX_PACKET_CONTROL:
          packet_access_control <= wr_byte & modem_packet_pkg::MASK_PACKET_CONTROL;
        modem_packet_pkg::IDX_MODE_CONTROL:
          mode_control <= wr_byte & modem_packet_pkg::MASK_MODE_CONTROL;
        default: ;
      endcase
    end
  end

  // Measurements captured from the modem; software cannot write them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      signal_strength   <= 8'h00;
      antenna1_strength <= 8'h00;
      antenna2_strength <= 8'h00;
    end else begin
      if (signal_strength_valid) begin
        signal_strength <= signal_strength_in;
      end
      if (antenna1_valid) begin
        antenna1_strength <= antenna1_strength_in;
      end
      if (antenna2_valid) begin
        antenna2_strength <= antenna2_strength_in;
      end
    end
  end

  // Clear-channel flag registered from the comparison, follows the level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clear_channel_irq <= 1'b0;
    end else begin
      clear_channel_irq <= signal_strength > clear_channel_threshold;
    end
  end

  // Read multiplexer; misses answer zero with an error response
  logic [8:0] rd_idx;
  assign rd_idx = decode_index(rd_addr);
  assign rd_ok  = is_mapped(rd_idx);

  always_comb begin
    rd_byte = 8'h00;
    if (!rd_idx[8]) begin
      unique case (rd_idx[7:0])
        modem_packet_pkg::IDX_OSR_LOW:         rd_byte = osr_low;
        modem_packet_pkg::IDX_OFFSET_HIGH:     rd_byte = clock_recovery_offset_high;
        modem_packet_pkg::IDX_OFFSET_MID:      rd_byte = clock_recovery_offset_mid;
        modem_packet_pkg::IDX_OFFSET_LOW:      rd_byte = clock_recovery_offset_low;
        modem_packet_pkg::IDX_GAIN_HIGH:       rd_byte = timing_loop_gain_high;
        modem_packet_pkg::IDX_GAIN_LOW:        rd_byte = timing_loop_gain_low;
        modem_packet_pkg::IDX_SIGNAL_STRENGTH: rd_byte = signal_strength;
        modem_packet_pkg::IDX_CC_THRESHOLD:    rd_byte = clear_channel_threshold;
        modem_packet_pkg::IDX_ANT1_STRENGTH:   rd_byte = antenna1_strength;
        modem_packet_pkg::IDX_ANT2_STRENGTH:   rd_byte = antenna2_strength;
        modem_packet_pkg::IDX_PACKET_CONTROL:  rd_byte = packet_access_control;
        modem_packet_pkg::IDX_MODE_CONTROL:    rd_byte = mode_control;
        default:                               rd_byte = 8'h00;
      endcase
    end
  end

  // Clock recovery configuration fields out to the modem
  assign oversampling_ratio = {clock_recovery_offset_high[modem_packet_pkg::OSR_HIGH_MSB:
                                 modem_packet_pkg::OSR_HIGH_LSB], osr_low};
  assign stall_control      = clock_recovery_offset_high[modem_packet_pkg::STALL_BIT];
  assign nco_offset         = {clock_recovery_offset_high[modem_packet_pkg::NCO_HIGH_MSB:0],
                               clock_recovery_offset_mid, clock_recovery_offset_low};
  assign loop_gain          = {timing_loop_gain_high[2:0], timing_loop_gain_low};

  // Packet engine controls; automation only applies in buffered mode
  assign transfer_mode      = mode_control[1:0];
  assign buffered           = transfer_mode == modem_packet_pkg::MODE_BUFFERED;
  assign rx_packet_handling = buffered
                              && packet_access_control[modem_packet_pkg::RX_PKT_BIT];
  assign rx_raw_capture     = !rx_packet_handling;
  assign tx_packet_handling = buffered
                              && packet_access_control[modem_packet_pkg::TX_PKT_BIT];
  assign tx_raw_send        = !tx_packet_handling;
  assign lsb_first          = packet_access_control[modem_packet_pkg::LSB_FIRST_BIT];
  assign crc_data_only      = packet_access_control[modem_packet_pkg::CRC_DATA_BIT];
  assign crc_enable         = packet_access_control[modem_packet_pkg::CRC_EN_BIT];
  assign crc_poly_select    = packet_access_control[modem_packet_pkg::CRC_SEL_MSB:0];

endmodule

// ### rtl/modem_packet_pkg.sv
// Package: register map, field positions and reset values of the modem/packet bank.
// Assumes byte-wide registers, each in one aligned 32-bit AXI4-Lite word.
package modem_packet_pkg;

  // Printed offsets are not multiples of four: they are word indices
  localparam logic [7:0] IDX_OSR_LOW          = 8'h20;
  localparam logic [7:0] IDX_OFFSET_HIGH      = 8'h21;
  localparam logic [7:0] IDX_OFFSET_MID       = 8'h22;
  localparam logic [7:0] IDX_OFFSET_LOW       = 8'h23;
  localparam logic [7:0] IDX_GAIN_HIGH        = 8'h24;
  localparam logic [7:0] IDX_GAIN_LOW         = 8'h25;
  localparam logic [7:0] IDX_SIGNAL_STRENGTH  = 8'h26;
  localparam logic [7:0] IDX_CC_THRESHOLD     = 8'h27;
  localparam logic [7:0] IDX_ANT1_STRENGTH    = 8'h28;
  localparam logic [7:0] IDX_ANT2_STRENGTH    = 8'h29;
  localparam logic [7:0] IDX_PACKET_CONTROL   = 8'h30;
  localparam logic [7:0] IDX_MODE_CONTROL     = 8'h3F;

  // Reset values
  localparam logic [7:0] RST_OSR_LOW          = 8'h64;
  localparam logic [7:0] RST_OFFSET_HIGH      = 8'h00;
  localparam logic [7:0] RST_OFFSET_MID       = 8'h47;
  localparam logic [7:0] RST_OFFSET_LOW       = 8'hAE;
  localparam logic [7:0] RST_GAIN_HIGH        = 8'h00;
  localparam logic [7:0] RST_GAIN_LOW         = 8'h8F;
  localparam logic [7:0] RST_CC_THRESHOLD     = 8'h00;
  localparam logic [7:0] RST_PACKET_CONTROL   = 8'h00;
  localparam logic [1:0] RST_TRANSFER_MODE    = 2'h0;

  // Writable bit masks; other bits are reserved
  localparam logic [7:0] MASK_GAIN_HIGH       = 8'h07;
  localparam logic [7:0] MASK_PACKET_CONTROL  = 8'hEF;
  localparam logic [7:0] MASK_MODE_CONTROL    = 8'h03;

  // Offset-high fields
  localparam int OSR_HIGH_MSB   = 7;
  localparam int OSR_HIGH_LSB   = 5;
  localparam int STALL_BIT      = 4;
  localparam int NCO_HIGH_MSB   = 3;
  // Packet control fields
  localparam int RX_PKT_BIT     = 7;
  localparam int LSB_FIRST_BIT  = 6;
  localparam int CRC_DATA_BIT   = 5;
  localparam int TX_PKT_BIT     = 3;
  localparam int CRC_EN_BIT     = 2;
  localparam int CRC_SEL_MSB    = 1;

  // Data transfer mode encoding
  localparam logic [1:0] MODE_BUFFERED = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CRC_CCITT    = 2'b00,
    CRC_IBM16    = 2'b01,
    CRC_IEC16    = 2'b10,
    CRC_BAICHEVA = 2'b11
  } crc_poly_e;

endpackage

// ### verif/modem_packet_config_regs_bench.sv
// Testbench: AXI4-Lite master tasks, random and corner register traffic.
// Assumes the bank alone on one 50 MHz clock, measurements driven here.
`timescale 1ns/100ps
module modem_packet_config_regs_bench;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, ss_v, a1_v, a2_v, stall, irq;
  logic        rxp, rxr, txp, txr, lsbf, crcd, crce;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, poly, mode, rs;
  logic [7:0]  ss_in, a1_in, a2_in, v, t, m;
  logic [7:0]  exp_reg [256];
  logic [10:0] osr, gain;
  logic [19:0] nco;
  int          error_cnt, tests_run, seed;
  logic [7:0]  regs [12] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
                             8'h28, 8'h29, 8'h30, 8'h3F};

  modem_packet_config_regs #(.ADDR_W(12)) i_modem_packet_config_regs (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .signal_strength_in(ss_in), .signal_strength_valid(ss_v), .antenna1_strength_in(a1_in),
    .antenna1_valid(a1_v), .antenna2_strength_in(a2_in), .antenna2_valid(a2_v),
    .oversampling_ratio(osr), .stall_control(stall), .nco_offset(nco), .loop_gain(gain),
    .clear_channel_irq(irq), .rx_packet_handling(rxp), .rx_raw_capture(rxr),
    .tx_packet_handling(txp), .tx_raw_send(txr), .lsb_first(lsbf), .crc_data_only(crcd),
    .crc_enable(crce), .crc_poly_select(poly), .transfer_mode(mode)
  );

  // Reset image of each register index
  function automatic logic [7:0] rst_val(input logic [7:0] idx);
    case (idx)
      8'h20: return 8'h64;
      8'h22: return 8'h47;
      8'h23: return 8'hAE;
      8'h25: return 8'h8F;
      default: return 8'h00;
    endcase
  endfunction

  // Bits that software may change; read-only places get none
  function automatic logic [7:0] wmask(input logic [7:0] idx);
    case (idx)
      8'h24: return 8'h07;
      8'h30: return 8'hEF;
      8'h3F: return modem_packet_pkg::MASK_MODE_CONTROL;
      8'h26, 8'h28, 8'h29: return 8'h00;
      default: return 8'hFF;
    endcase
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    @(posedge aclk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h000000, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rs = bresp;
  endtask

  task automatic rd_reg(input logic [7:0] idx);
    @(posedge aclk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Free-running 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Hang guard of 20000 cycles, far beyond the thousand or so cycles the tests need
  initial begin
    #400000;
    error_cnt++;
    test_done;
  end

  initial begin
    seed = 524;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ss_v, a1_v, a2_v} = '0;
    {awaddr, araddr, wdata, ss_in, a1_in, a2_in} = '0;
    wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset image of the whole map
    foreach (regs[k]) begin
      exp_reg[regs[k]] = rst_val(regs[k]);
      rd_reg(regs[k]);
      check("reset value", {24'h000000, exp_reg[regs[k]]}, rd);
    end
    $display("test reset done");
    // Corner rounds set every polynomial with both paths on, then random bytes
    for (int r = 0; r < 12; r++) begin
      foreach (regs[k]) begin
        v = (r < 4) ? ((regs[k] == 8'h3F) ? 8'h02 : (8'hFC | r[7:0])) : 8'($random(seed));
        m = wmask(regs[k]);
        exp_reg[regs[k]] = (exp_reg[regs[k]] & ~m) | (v & m);
        wr(regs[k], v);
        check("write resp", modem_packet_pkg::RESP_OKAY, rs);
        rd_reg(regs[k]);
        check("readback", {24'h000000, exp_reg[regs[k]]}, rd);
        check("read resp", modem_packet_pkg::RESP_OKAY, rs);
      end
      check("mode", exp_reg[8'h3F][1:0], mode);
      check("ratio", {exp_reg[8'h21][7:5], exp_reg[8'h20]}, osr);
      check("stall", exp_reg[8'h21][4], stall);
      check("nco", {exp_reg[8'h21][3:0], exp_reg[8'h22], exp_reg[8'h23]}, nco);
      check("gain", {exp_reg[8'h24][2:0], exp_reg[8'h25]}, gain);
      v = exp_reg[8'h30];
      m = {7'h00, exp_reg[8'h3F][1:0] == modem_packet_pkg::MODE_BUFFERED};
      check("handling", {m[0] & v[7], !(m[0] & v[7]), m[0] & v[3], !(m[0] & v[3])},
            {rxp, rxr, txp, txr});
      check("crc setup", {v[6], v[5], v[2], v[1:0]},
            {lsbf, crcd, crce, poly});
    end
    $display("test registers done");
    // Measurements latch on valid and ignore input while it is low
    @(posedge aclk);
    exp_reg[8'h26] = 8'($random(seed));
    exp_reg[8'h28] = 8'($random(seed));
    exp_reg[8'h29] = 8'($random(seed));
    {ss_in, a1_in, a2_in} <= {exp_reg[8'h26], exp_reg[8'h28], exp_reg[8'h29]};
    {ss_v, a1_v, a2_v} <= 3'b111;
    @(posedge aclk);
    {ss_v, a1_v, a2_v} <= 3'b000;
    {ss_in, a1_in, a2_in} <= ~{exp_reg[8'h26], exp_reg[8'h28], exp_reg[8'h29]};
    foreach (regs[k]) begin
      rd_reg(regs[k]);
      check("strength", {24'h000000, exp_reg[regs[k]]}, rd);
    end
    $display("test strength done");
    // Threshold: one above sets the flag, equal and zero clear it
    t = {1'b0, 7'($random(seed))};
    wr(8'h27, t);
    ss_v <= 1'b1;
    ss_in <= t + 8'h01;
    repeat (3) @(posedge aclk);
    check("flag above", 1'b1, irq);
    ss_in <= t;
    repeat (3) @(posedge aclk);
    check("flag equal", 1'b0, irq);
    ss_in <= 8'h00;
    repeat (3) @(posedge aclk);
    ss_v <= 1'b0;
    check("flag zero", 1'b0, irq);
    $display("test threshold done");
    // Unmapped word answers with an error and zero data
    rd_reg(8'h10);
    check("unmapped rresp", modem_packet_pkg::RESP_SLVERR, rs);
    check("unmapped rdata", 32'h00000000, rd);
    wr(8'h10, 8'h5A);
    check("unmapped write", modem_packet_pkg::RESP_SLVERR, rs);
    // Lane 0 strobe low: acknowledged, nothing stored
    wstrb <= 4'hE;
    wr(8'h27, ~t);
    check("strobe off resp", modem_packet_pkg::RESP_OKAY, rs);
    wstrb <= 4'hF;
    rd_reg(8'h27);
    check("strobe off", {24'h000000, t}, rd);
    $display("test unmapped done");
    test_done;
  end
endmodule

// ### verif/modem_packet_config_regs_properties.sv
// Checker: concurrent properties on the register bank's top-level ports.
// Assumes one aclk domain and the bank's synchronous active-low reset.
`timescale 1ns/100ps
module modem_packet_config_regs_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0]  signal_strength_in,
  input wire logic        signal_strength_valid,
  input wire logic [10:0] oversampling_ratio,
  input wire logic        stall_control,
  input wire logic [19:0] nco_offset,
  input wire logic [10:0] loop_gain,
  input wire logic        clear_channel_irq,
  input wire logic        rx_packet_handling,
  input wire logic        rx_raw_capture,
  input wire logic        tx_packet_handling,
  input wire logic        tx_raw_send,
  input wire logic        lsb_first,
  input wire logic        crc_data_only,
  input wire logic        crc_enable,
  input wire logic [1:0]  crc_poly_select,
  input wire logic [1:0]  transfer_mode
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Two quiet samples in a row leave nothing above any threshold
  sequence seq_quiet_pair;
    (signal_strength_valid && signal_strength_in == 8'h00) [*2];
  endsequence

  // Settings move only at the edge that completes a write
  AST_OSR_WRITE: assert property (!$stable({oversampling_ratio, stall_control})
    |-> $rose(s_axi_bvalid))
    else $error("ratio or stall moved without a write");
  AST_NCO_WRITE: assert property (!$stable(nco_offset) |-> $rose(s_axi_bvalid))
    else $error("nco offset moved without a write");
  AST_GAIN_WRITE: assert property (!$stable(loop_gain) |-> $rose(s_axi_bvalid))
    else $error("loop gain moved without a write");
  AST_CRC_WRITE: assert property (!$stable({lsb_first, crc_data_only, crc_enable})
    || !$stable(crc_poly_select) |-> $rose(s_axi_bvalid))
    else $error("packet control moved without a write");
  AST_IRQ_QUIET: assert property (seq_quiet_pair |=> !clear_channel_irq)
    else $error("clear channel flag with zero strength");
  AST_RX_MODE: assert property (rx_packet_handling
    |-> transfer_mode == modem_packet_pkg::MODE_BUFFERED)
    else $error("rx handling outside buffered mode");
  AST_RX_RAW: assert property (rx_raw_capture != rx_packet_handling)
    else $error("rx raw capture not inverse of handling");
  AST_TX_MODE: assert property (tx_packet_handling
    |-> transfer_mode == modem_packet_pkg::MODE_BUFFERED)
    else $error("tx handling outside buffered mode");
  AST_TX_RAW: assert property (tx_raw_send != tx_packet_handling)
    else $error("tx raw send not inverse of handling");
  AST_RSV_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
endmodule

bind modem_packet_config_regs modem_packet_config_regs_chk i_chk (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rdata, .signal_strength_in,
  .signal_strength_valid, .oversampling_ratio, .stall_control, .nco_offset, .loop_gain,
  .clear_channel_irq, .rx_packet_handling, .rx_raw_capture, .tx_packet_handling, .tx_raw_send,
  .lsb_first, .crc_data_only, .crc_enable, .crc_poly_select, .transfer_mode
);
